/* shared/sadc_pkg.sv */
// package of constants for the sampling converter control block
package sadc_pkg;
  localparam int          CLK_MHZ         = 250;
  localparam int          POWERUP_NS      = 1500;
  localparam int          CONV_NS         = 2300;
  localparam int          POWERUP_CYCLES  = (POWERUP_NS * CLK_MHZ + 999) / 1000;
  localparam int          CONV_CYCLES     = (CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int          CNT_W           = 12;
  localparam int          RESULT_W        = 10;
  localparam int          BYTE_W          = 8;
  localparam int          LSB_W           = 2;
  localparam int          BUF_DEPTH       = 2;
  localparam logic [CNT_W-1:0] POWERUP_LAST = CNT_W'(POWERUP_CYCLES - 1);
  localparam logic [CNT_W-1:0] CONV_LAST    = CNT_W'(CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO     = 12'h000;
  typedef enum logic [1:0] {SADC_IDLE, SADC_CONVERT} sadc_state_type;
endpackage

/* design/sadc_control.sv */
// control, power-down and parallel read logic of the sampling converter
`timescale 1ns/1ps
module sadc_control (
  input  wire logic                            clk_sys_in,
  input  wire logic                            reset_in,
  input  wire logic                            convert_start_n_in,
  input  wire logic                            chip_select_n_in,
  input  wire logic                            read_n_in,
  input  wire logic [sadc_pkg::RESULT_W-1:0]   sample_code_in,
  output logic                                 busy_out,
  output logic                                 powered_down_out,
  output logic                                 powerup_pulse_out,
  output logic [sadc_pkg::BYTE_W-1:0]          result_bus_out,
  output logic [sadc_pkg::BYTE_W-1:0]          result_bus_oe_out
);
  import sadc_pkg::*;

  // ==========================================================
  // input synchronisers
  logic [1:0] cs_sync;
  logic [1:0] cs_n_sync;
  logic [1:0] rd_n_sync;
  logic       conv_prev;
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      cs_sync   <= 2'h0;
      cs_n_sync <= 2'h3;
      rd_n_sync <= 2'h3;
      conv_prev <= 1'b0;
    end else begin
      cs_sync   <= {cs_sync[0], convert_start_n_in};
      cs_n_sync <= {cs_n_sync[0], chip_select_n_in};
      rd_n_sync <= {rd_n_sync[0], read_n_in};
      conv_prev <= cs_sync[1];
    end
  end
  logic conv_level;
  logic conv_rise;
  logic conv_fall;
  assign conv_level = cs_sync[1];
  assign conv_rise  = conv_level & ~conv_prev;
  assign conv_fall  = ~conv_level & conv_prev;

  // ==========================================================
  // power-up pulse and power state
  logic [CNT_W-1:0] pu_cnt;
  logic             pending;
  sadc_state_type   state;
  logic [CNT_W-1:0] cv_cnt;
  logic             conv_done;
  logic             buf_in_ready;
  assign conv_done = (state == SADC_CONVERT) && (cv_cnt == CONV_LAST);

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      powerup_pulse_out <= 1'b0;
      pu_cnt            <= CNT_ZERO;
    end else if (conv_rise) begin
      powerup_pulse_out <= 1'b1;
      pu_cnt            <= CNT_ZERO;
    end else if (powerup_pulse_out) begin
      pu_cnt <= pu_cnt + 12'h001;
      if (pu_cnt == POWERUP_LAST) begin
        powerup_pulse_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      powered_down_out <= 1'b1;
    end else if (conv_rise) begin
      powered_down_out <= 1'b0;
    end else if (conv_done && buf_in_ready) begin
      // decided only when busy really falls; a stalled finish stays powered
      powered_down_out <= ~conv_level;
    end
  end

  // ==========================================================
  // conversion sequencer; a fall during the pulse while idle is held until it ends
  logic start_now;
  assign start_now = (conv_fall | pending) & ~powerup_pulse_out & ~conv_rise;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pending <= 1'b0;
    end else if (state == SADC_IDLE && conv_fall && powerup_pulse_out) begin
      pending <= 1'b1;
    end else if (start_now || conv_rise) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state    <= SADC_IDLE;
      cv_cnt   <= CNT_ZERO;
      busy_out <= 1'b0;
    end else begin
      case (state)
        SADC_IDLE: begin
          if (start_now) begin
            state    <= SADC_CONVERT;
            cv_cnt   <= CNT_ZERO;
            busy_out <= 1'b1;
          end
        end
        SADC_CONVERT: begin
          // a full buffer stalls the finish so no result is lost
          if (cv_cnt == CONV_LAST) begin
            if (buf_in_ready) begin
              state    <= SADC_IDLE;
              busy_out <= 1'b0;
            end
          end else begin
            cv_cnt <= cv_cnt + 12'h001;
          end
        end
        default: begin
          state    <= SADC_IDLE;
          busy_out <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // two-entry result buffer
  logic [RESULT_W-1:0] buf_mem [BUF_DEPTH];
  logic                wr_ptr;
  logic                rd_ptr;
  logic [1:0]          count;
  logic                buf_push;
  logic                buf_pop;
  logic                buf_out_valid;
  assign buf_in_ready  = (count != 2'h2);
  assign buf_out_valid = (count != 2'h0);
  assign buf_push      = conv_done & buf_in_ready;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (buf_push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (buf_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < BUF_DEPTH; gi++) begin : g_entry
      always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
          buf_mem[gi] <= 10'h000;
        end else if (buf_push && (wr_ptr == 1'(gi))) begin
          buf_mem[gi] <= sample_code_in;
        end
      end
    end
  endgenerate

  // ==========================================================
  // byte reads: high byte first, low two bits second, then entry pops
  logic rd_active;
  logic rd_prev;
  logic second_byte;
  assign rd_active = ~cs_n_sync[1] & ~rd_n_sync[1];
  assign buf_pop   = rd_prev & ~rd_active & second_byte & buf_out_valid;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rd_prev     <= 1'b0;
      second_byte <= 1'b0;
    end else begin
      rd_prev <= rd_active;
      if (rd_prev && !rd_active) begin
        second_byte <= ~second_byte;
      end
    end
  end

  logic [RESULT_W-1:0] head;
  assign head = buf_mem[rd_ptr];
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      result_bus_out    <= 8'h00;
      result_bus_oe_out <= 8'h00;
    end else begin
      result_bus_oe_out <= {BYTE_W{rd_active}};
      if (second_byte) begin
        result_bus_out <= {6'h00, head[LSB_W-1:0]};
      end else begin
        result_bus_out <= head[RESULT_W-1:LSB_W];
      end
    end
  end

  // ==========================================================
  // checks
  AST_PULSE_LEN: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(powerup_pulse_out) && !conv_rise |-> powerup_pulse_out [*8])
    else $error("power-up pulse too short");
  AST_NO_START_IN_PULSE: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(busy_out) |-> !$past(powerup_pulse_out))
    else $error("conversion began during power-up pulse");
  AST_BUSY_LEN: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(busy_out) |-> busy_out [*8])
    else $error("busy dropped early");
  AST_BUSY_STATE: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    busy_out == (state == SADC_CONVERT))
    else $error("busy disagrees with conversion state");
  AST_AUTO_PD: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    buf_push && !conv_rise |=> powered_down_out == !$past(conv_level))
    else $error("power-down choice wrong");
  AST_PU_ON_RISE: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    conv_rise |=> !powered_down_out && powerup_pulse_out)
    else $error("no power-up on rise");
  AST_BUS_FLOAT: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    !rd_active |=> result_bus_oe_out == 8'h00)
    else $error("bus driven without read");
  AST_LSB_FORM: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $past(second_byte) |-> result_bus_out[7:2] == 6'h00)
    else $error("low byte upper bits not zero");
  AST_BUSY_FALL: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $fell(busy_out) |-> count != 2'h0)
    else $error("busy fell without result");
  COV_CONVERT: cover property (@(posedge clk_sys_in) $fell(busy_out));
  COV_DEFER: cover property (@(posedge clk_sys_in) pending && $fell(powerup_pulse_out));
  COV_FULL: cover property (@(posedge clk_sys_in) count == 2'h2);
  COV_TWO_READS: cover property (@(posedge clk_sys_in) buf_pop);
endmodule

/* verif/sadc_host_model.sv */
// host model: drives convert start, chip select and read strobe
`timescale 1ns/1ps
module sadc_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] bus_in,
  input  wire logic [7:0] oe_in,
  output logic            convert_start_n_out,
  output logic            chip_select_n_out,
  output logic            read_n_out
);
  initial begin
    convert_start_n_out = 1'b0;
    chip_select_n_out   = 1'b1;
    read_n_out          = 1'b1;
  end
  // ==========================================
  // conversion request
  task automatic convert(input int gap, input logic keep);
    repeat (30) @(posedge clk_in);
    if (convert_start_n_out === 1'b0) begin
      @(posedge clk_in) #1 convert_start_n_out = 1'b1;
      repeat (gap) @(posedge clk_in);
    end
    @(posedge clk_in) #1 convert_start_n_out = 1'b0;
    repeat (20) @(posedge clk_in);
    // high level at the end keeps the converter powered
    if (keep) #1 convert_start_n_out = 1'b1;
  endtask
  // ==========================================
  // byte read, select before strobe
  task automatic read_byte(output logic [7:0] data, output logic ok);
    ok = 1'b0;
    @(posedge clk_in) #1 chip_select_n_out = 1'b0;
    @(posedge clk_in) #1 read_n_out = 1'b0;
    for (int i = 0; i < 8 && !ok; i++) begin
      @(posedge clk_in);
      ok = (oe_in === 8'hFF);
    end
    data = bus_in;
    #1 read_n_out = 1'b1;
    @(posedge clk_in) #1 chip_select_n_out = 1'b1;
  endtask
endmodule

/* verif/sampling_adc_parallel_control_bench.sv */
// self-checking bench for the converter control block
`timescale 1ns/1ps
module sampling_adc_parallel_control_bench;
  import sadc_pkg::*;
  logic                clk_sys_in     = 1'b0;
  logic                reset_in       = 1'b1;
  logic [RESULT_W-1:0] sample_code_in = 10'h000;
  logic                cs_n, rd_n, conv_n, busy, pdown, pulse;
  logic [BYTE_W-1:0]   bus, oe;
  int                  n_fail = 0, tests_run = 0, pulse_len = 0, busy_len = 0;
  int                  p_cnt = 0, b_cnt = 0;
  logic [RESULT_W-1:0] codes[$];
  always #2 clk_sys_in = ~clk_sys_in;
  sadc_control DUT (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .convert_start_n_in(conv_n), .chip_select_n_in(cs_n), .read_n_in(rd_n),
    .sample_code_in(sample_code_in), .busy_out(busy), .powered_down_out(pdown),
    .powerup_pulse_out(pulse), .result_bus_out(bus), .result_bus_oe_out(oe));
  sadc_host_model HOST (.clk_in(clk_sys_in), .bus_in(bus), .oe_in(oe),
    .convert_start_n_out(conv_n), .chip_select_n_out(cs_n), .read_n_out(rd_n));
  // ==========================================
  // compare and report
  task automatic cmp_val(input logic [BYTE_W-1:0] act, exp, input string what);
    tests_run++;
    if (act !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task automatic cmp_cnt(input int act, exp, input string what);
    tests_run++;
    if (act != exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s %0d", $time, what, act);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================
  // duration monitor
  always @(posedge clk_sys_in) begin
    p_cnt <= pulse ? p_cnt + 1 : 0;
    if (!pulse && p_cnt != 0) pulse_len <= p_cnt;
    b_cnt <= busy ? b_cnt + 1 : 0;
    if (!busy && b_cnt != 0) busy_len <= b_cnt;
    if (busy && b_cnt == 0) begin
      cmp_val(BYTE_W'(pulse), 8'h00, "start while powering up");
      cmp_val(BYTE_W'(pdown), 8'h00, "start while powered down");
    end
  end
  // ==========================================
  // sequences
  task automatic wait_busy(input logic lvl);
    int i;
    for (i = 0; i < 2000 && busy !== lvl; i++) @(posedge clk_sys_in);
    if (busy !== lvl) begin
      n_fail++;
      $display("CHECK FAILED %0t busy wait", $time);
      end_sim();
    end
  endtask
  task automatic conv(input int gap, input logic keep, input logic chk);
    logic [RESULT_W-1:0] code;
    code = RESULT_W'($urandom);
    @(posedge clk_sys_in) #1 sample_code_in = code;
    codes.push_back(code);
    HOST.convert(gap, keep);
    if (chk) begin
      wait_busy(1'b1);
      wait_busy(1'b0);
      repeat (3) @(posedge clk_sys_in);
      cmp_cnt(busy_len, CONV_CYCLES, "busy length");
      cmp_cnt(pulse_len, POWERUP_CYCLES, "pulse length");
      cmp_val(BYTE_W'(pdown), BYTE_W'(!keep), "power state");
    end
  endtask
  task automatic rd_pair();
    logic [BYTE_W-1:0]   hi, lo;
    logic                ok1, ok2;
    logic [RESULT_W-1:0] exp;
    exp = codes.pop_front();
    HOST.read_byte(hi, ok1);
    repeat (4) @(posedge clk_sys_in);
    HOST.read_byte(lo, ok2);
    repeat (4) @(posedge clk_sys_in);
    cmp_val(BYTE_W'({ok1, ok2}), 8'h03, "bus enable");
    cmp_val(hi, exp[RESULT_W-1:LSB_W], "high byte");
    cmp_val(lo, {6'h00, exp[LSB_W-1:0]}, "low byte");
    cmp_val(oe, 8'h00, "bus released");
  endtask
  initial begin
    void'($urandom(6));
    repeat (16) @(posedge clk_sys_in);
    #1 reset_in = 1'b0;
    @(posedge clk_sys_in);
    cmp_val(BYTE_W'({busy, pdown}), 8'h01, "reset state");
    cmp_val(oe, 8'h00, "bus floats");
    // fall inside the power-up pulse must wait for it
    conv(50, 1'b0, 1'b1);
    rd_pair();
    for (int k = 0; k < 5; k++) begin
      conv($urandom_range(600, 380), 1'($urandom_range(1, 0)), 1'b1);
      rd_pair();
    end
    // two unread results fill the buffer, the third must hold busy
    conv(400, 1'b0, 1'b1);
    conv(400, 1'b0, 1'b1);
    conv(400, 1'b0, 1'b0);
    repeat (800) @(posedge clk_sys_in);
    cmp_val(BYTE_W'(busy), 8'h01, "stall while full");
    cmp_val(BYTE_W'(pdown), 8'h00, "powered down while stalled");
    rd_pair();
    rd_pair();
    wait_busy(1'b0);
    repeat (3) @(posedge clk_sys_in);
    rd_pair();
    end_sim();
  end
endmodule
